// ==== logic/mieu_pkg.sv ====
/*
  Package for the instruction execute unit: opcode set, flag layout,
  field positions and reset constants.
  Assumes a single 25 MHz core clock and a decoded opcode from fetch.
*/
package mieu_pkg;
  localparam int MIEU_DW = 8;
  localparam int MIEU_PCW = 13;
  localparam int MIEU_AW = 8;
  localparam int MIEU_SPW = 3;
  localparam int MIEU_SDEPTH = 8;
  localparam int MIEU_WDTW = 8;

  // status flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_PD = 4;
  localparam int FLG_TO = 5;

  localparam logic [MIEU_DW-1:0] MIEU_ALL_ONES = 8'hff;
  localparam logic [MIEU_DW-1:0] MIEU_ZERO = 8'h00;
  localparam logic [5:0] MIEU_FLAGS_RST = 6'h00;
  localparam logic [MIEU_PCW-1:0] MIEU_PC_RST = 13'h0000;
  localparam logic [MIEU_PCW-1:0] MIEU_PC_ONE = 13'h0001;
  localparam logic [MIEU_DW-1:0] MIEU_ONE = 8'h01;
  localparam logic [MIEU_WDTW-1:0] MIEU_WDT_RST = 8'h00;
  localparam logic [MIEU_WDTW-1:0] MIEU_WDT_ONE = 8'h01;
  localparam logic [MIEU_AW-1:0] MIEU_PCL_ADDR = 8'h06;
  localparam logic [MIEU_DW-1:0] MIEU_LAST_PAGE = 8'hff;

  // register offsets (word addresses on the bus, byte address = 4x)
  localparam logic [3:0] MIEU_R_CMD = 4'h0;
  localparam logic [3:0] MIEU_R_STATUS = 4'h1;
  localparam logic [3:0] MIEU_R_PC = 4'h2;
  localparam logic [3:0] MIEU_R_ACC = 4'h3;

  typedef enum logic [4:0] {
    OP_NOP, OP_MOV_A_M, OP_MOV_M_A, OP_MOV_A_X, OP_BCLR, OP_BSET, OP_JMP,
    OP_SZ, OP_SZA, OP_SZB, OP_SNZB, OP_SIZ, OP_SDZ, OP_INC_TO_REG_SKIP_IF_NULL, OP_DEC_TO_REG_SKIP_IF_NULL,
    OP_CALL, OP_RET, OP_RETA, OP_RETURN_FROM_IRQ, OP_TABLE_READ_SPECIFIC_PAGE_S, OP_TABLE_READ_SPECIFIC_PAGE_C, OP_TABLE_READ_SPECIFIC_PAGE_L,
    OP_CLR, OP_SET, OP_KICK, OP_PRE1, OP_PRE2, OP_SWAP, OP_NIBBLE_SWAP_TO_REGISTER, OP_HALT,
    OP_ADD
  } mieu_op_t;

  // alu sub-select carried in the instruction word for OP_ADD
  typedef struct packed {
    logic with_carry;
    logic literal;
    logic to_mem;
    logic logic_and;
  } mieu_alu_sel_t;

  typedef struct packed {
    mieu_op_t op;
    mieu_alu_sel_t alu;
    logic [2:0] bit_sel;
    logic [MIEU_AW-1:0] mem_addr;
    logic [MIEU_DW-1:0] literal;
    logic [MIEU_PCW-1:0] target;
  } mieu_instr_t;
endpackage

// ==== logic/mieu_core.sv ====
/*
  Instruction execute unit of an 8-bit core: executes one decoded
  instruction per issue, holds working register, flags, pc, stack,
  watchdog counter and table latch.
  Assumes an instruction source with valid/ready handshake, a combinational
  data memory read port, a combinational program-memory read port
  and an Avalon-MM slave port for the status registers.
*/
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - moves take one cycle (two when writing pc low byte), flags untouched
// - call pushes pc+1, jumps, two cycles
// - skips take two cycles when skipping
// - writing pc low byte takes two cycles
// - returns take two cycles; literal loads register
// - kick clears watchdog and both flags
// - prekicks act only as consecutive pair
// - add with carry into working register
// - memory-destination adds write data byte
// - add literal into working register, four flags
// - and affects only zero flag
// - clear byte zeros, set byte ones
// - bit clear/set touches only selected bit
// - table reads fill latch and byte, two cycles
// - nibble swap; register form leaves memory
// - bit tests skip on clear or set
// - inc/dec skip on zero result
// - load-and-test copies byte, skips on zero
// - halt holds until wake_in, only timeout/powerdown flags
// - halt stops execution, sets powerdown, clears timeout
// - irq return restores pc, sets global enable
module mieu_core
  import mieu_pkg::*;
#(
  parameter int DW = MIEU_DW
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire mieu_instr_t instr_in,
  input wire logic instr_valid_in,
  output logic instr_ready_out,
  input wire logic wake_in,
  input wire logic [DW-1:0] mem_rdata_in,
  output logic [MIEU_AW-1:0] mem_addr_out,
  output logic [DW-1:0] mem_wdata_out,
  output logic mem_we_out,
  output logic [15:0] prog_addr_out,
  input wire logic [15:0] prog_rdata_in,
  output logic [MIEU_PCW-1:0] pc_out,
  output logic [DW-1:0] working_register_out,
  output logic [DW-1:0] table_high_latch_out,
  output logic [5:0] flags_out,
  output logic global_irq_enable_out,
  output logic halted_out,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [1:0] {ST_EXEC, ST_DUMMY, ST_HALT} mieu_state_t;

  mieu_state_t state_reg, state_next;
  logic [DW-1:0] acc_reg;
  logic [5:0] flags_reg;
  logic [MIEU_PCW-1:0] pc_reg;
  logic [MIEU_PCW-1:0] stack_mem [MIEU_SDEPTH];
  logic [MIEU_SPW-1:0] sp_reg;
  logic [MIEU_WDTW-1:0] watchdog_counter_reg;
  logic [DW-1:0] table_high_latch_reg;
  logic irq_en_reg, prekick1_reg, prekick2_reg;
  logic [MIEU_AW-1:0] tbl_addr_reg;
  logic tbl_pend_reg;
  logic [MIEU_AW-1:0] maddr_reg;
  logic [DW-1:0] mwdata_reg;
  logic mwe_reg;
  logic [15:0] paddr_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic [DW-1:0] tbl_page_reg;

  function automatic logic [DW-1:0] bit_mask(input logic [2:0] sel);
    bit_mask = MIEU_ONE << sel;
  endfunction

  function automatic logic is_zero(input logic [DW-1:0] v);
    is_zero = (v == MIEU_ZERO);
  endfunction

  wire issue = (state_reg == ST_EXEC) && instr_valid_in && !tbl_pend_reg;
  wire mieu_op_t op = instr_in.op;
  wire [DW-1:0] m = mem_rdata_in;
  wire [DW-1:0] mask = bit_mask(instr_in.bit_sel);
  wire [DW-1:0] alu_b = instr_in.alu.literal ? instr_in.literal : m;
  wire cin = instr_in.alu.with_carry & flags_reg[FLG_C];
  // 4-bit and 8-bit partial sums give half carry and carry
  wire [4:0] sum_lo = {1'b0, acc_reg[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
  wire [DW:0] sum = {1'b0, acc_reg} + {1'b0, alu_b} + {{DW{1'b0}}, cin};
  wire ovf = (acc_reg[DW-1] == alu_b[DW-1]) && (sum[DW-1] != acc_reg[DW-1]);
  wire [DW-1:0] and_res = acc_reg & alu_b;
  wire [DW-1:0] alu_res = instr_in.alu.logic_and ? and_res : sum[DW-1:0];
  wire [DW-1:0] inc_res = m + MIEU_ONE;
  wire [DW-1:0] dec_res = m - MIEU_ONE;
  wire [DW-1:0] swap_res = {m[3:0], m[7:4]};
  wire sel_bit = |(m & mask);

  // skip decisions
  wire skip = (op == OP_SZ && is_zero(m)) || (op == OP_SZA && is_zero(m))
    || (op == OP_SZB && !sel_bit) || (op == OP_SNZB && sel_bit)
    || ((op == OP_SIZ || op == OP_INC_TO_REG_SKIP_IF_NULL) && is_zero(inc_res))
    || ((op == OP_SDZ || op == OP_DEC_TO_REG_SKIP_IF_NULL) && is_zero(dec_res));

  // memory write data and enable
  logic [DW-1:0] wr_data;
  logic wr_en;
  always_comb begin
    wr_data = MIEU_ZERO;
    wr_en = 1'b0;
    unique case (op)
      OP_MOV_M_A: begin wr_data = acc_reg; wr_en = 1'b1; end
      OP_BCLR: begin wr_data = m & ~mask; wr_en = 1'b1; end
      OP_BSET: begin wr_data = m | mask; wr_en = 1'b1; end
      OP_CLR: begin wr_data = MIEU_ZERO; wr_en = 1'b1; end
      OP_SET: begin wr_data = MIEU_ALL_ONES; wr_en = 1'b1; end
      OP_SIZ: begin wr_data = inc_res; wr_en = 1'b1; end
      OP_SDZ: begin wr_data = dec_res; wr_en = 1'b1; end
      OP_SWAP: begin wr_data = swap_res; wr_en = 1'b1; end
      OP_ADD: begin wr_data = alu_res; wr_en = instr_in.alu.to_mem; end
      default: begin wr_data = MIEU_ZERO; wr_en = 1'b0; end
    endcase
  end

  // working register next value
  logic [DW-1:0] acc_next;
  always_comb begin
    acc_next = acc_reg;
    unique case (op)
      OP_MOV_A_M, OP_SZA: acc_next = m;
      OP_MOV_A_X, OP_RETA: acc_next = instr_in.literal;
      OP_INC_TO_REG_SKIP_IF_NULL: acc_next = inc_res;
      OP_DEC_TO_REG_SKIP_IF_NULL: acc_next = dec_res;
      OP_NIBBLE_SWAP_TO_REGISTER: acc_next = swap_res;
      OP_ADD: acc_next = instr_in.alu.to_mem ? acc_reg : alu_res;
      default: acc_next = acc_reg;
    endcase
  end

  wire pair_done = (op == OP_PRE1 && prekick2_reg) || (op == OP_PRE2 && prekick1_reg);
  wire wdt_clear = issue && (op == OP_KICK || pair_done || op == OP_HALT);

  // flags next value
  logic [5:0] flags_next;
  always_comb begin
    flags_next = flags_reg;
    if (op == OP_ADD) begin
      flags_next[FLG_Z] = is_zero(alu_res);
      if (!instr_in.alu.logic_and) begin
        flags_next[FLG_C] = sum[DW];
        flags_next[FLG_AC] = sum_lo[4];
        flags_next[FLG_OV] = ovf;
      end
    end
    if (op == OP_KICK || pair_done) begin
      flags_next[FLG_TO] = 1'b0;
      flags_next[FLG_PD] = 1'b0;
    end
    if (op == OP_HALT) begin
      flags_next[FLG_TO] = 1'b0;
      flags_next[FLG_PD] = 1'b1;
    end
  end

  wire pc_write = wr_en && (instr_in.mem_addr == MIEU_PCL_ADDR);
  wire is_ret = op == OP_RET || op == OP_RETA || op == OP_RETURN_FROM_IRQ;
  wire is_tbl = op == OP_TABLE_READ_SPECIFIC_PAGE_S || op == OP_TABLE_READ_SPECIFIC_PAGE_C || op == OP_TABLE_READ_SPECIFIC_PAGE_L;
  wire two_cycle = skip || pc_write || is_ret || is_tbl || op == OP_CALL || op == OP_JMP;
  wire [MIEU_SPW-1:0] sp_top = sp_reg - MIEU_SPW'(1);
  wire [MIEU_PCW-1:0] pc_inc = pc_reg + MIEU_PC_ONE;

  logic [MIEU_PCW-1:0] pc_next;
  always_comb begin
    pc_next = pc_reg;
    if (issue) begin
      if (op == OP_JMP || op == OP_CALL)
        pc_next = instr_in.target;
      else if (is_ret)
        pc_next = stack_mem[sp_top];
      else if (pc_write)
        pc_next = {pc_reg[MIEU_PCW-1:DW], wr_data};
      else if (skip)
        pc_next = pc_reg + MIEU_PCW'(2);
      else if (op != OP_HALT)
        pc_next = pc_inc;
    end
  end

  // table page select
  logic [DW-1:0] tbl_hi;
  always_comb begin
    unique case (op)
      OP_TABLE_READ_SPECIFIC_PAGE_C: tbl_hi = DW'(pc_reg[MIEU_PCW-1:DW]);
      OP_TABLE_READ_SPECIFIC_PAGE_L: tbl_hi = MIEU_LAST_PAGE;
      default: tbl_hi = tbl_page_reg;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_EXEC: begin
        if (issue && op == OP_HALT)
          state_next = ST_HALT;
        else if (issue && two_cycle)
          state_next = ST_DUMMY;
      end
      ST_DUMMY: state_next = ST_EXEC;
      ST_HALT: if (wake_in) state_next = ST_EXEC;
    endcase
  end

  // register bus: one-cycle wait then answer
  wire bus_req = (avs_read || avs_write) && !ack_reg;
  wire [31:0] rd_mux = (avs_address == MIEU_R_STATUS) ? {26'h0, flags_reg} :
    (avs_address == MIEU_R_PC) ? {19'h0, pc_reg} :
    (avs_address == MIEU_R_ACC) ? {24'h0, acc_reg} :
    (avs_address == MIEU_R_CMD) ? {24'h0, tbl_page_reg} : 32'h0;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_EXEC;
      acc_reg <= MIEU_ZERO;
      flags_reg <= MIEU_FLAGS_RST;
      pc_reg <= MIEU_PC_RST;
      sp_reg <= '0;
      irq_en_reg <= 1'b0;
      prekick1_reg <= 1'b0;
      prekick2_reg <= 1'b0;
      watchdog_counter_reg <= MIEU_WDT_RST;
      tbl_pend_reg <= 1'b0;
      tbl_addr_reg <= '0;
      table_high_latch_reg <= MIEU_ZERO;
      maddr_reg <= '0;
      mwdata_reg <= MIEU_ZERO;
      mwe_reg <= 1'b0;
      paddr_reg <= 16'h0000;
      tbl_page_reg <= MIEU_ZERO;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      mwe_reg <= 1'b0;
      maddr_reg <= instr_in.mem_addr;
      // halt freezes the watchdog as the clock would be stopped
      if (wdt_clear)
        watchdog_counter_reg <= MIEU_WDT_RST;
      else if (state_reg != ST_HALT)
        watchdog_counter_reg <= watchdog_counter_reg + MIEU_WDT_ONE;
      if (tbl_pend_reg) begin
        table_high_latch_reg <= prog_rdata_in[15:8];
        mwdata_reg <= prog_rdata_in[7:0];
        maddr_reg <= tbl_addr_reg;
        mwe_reg <= 1'b1;
        tbl_pend_reg <= 1'b0;
      end
      if (ack_reg && avs_write && avs_address == MIEU_R_CMD)
        tbl_page_reg <= avs_writedata[DW-1:0];
      if (issue) begin
        acc_reg <= acc_next;
        flags_reg <= flags_next;
        mwdata_reg <= wr_data;
        mwe_reg <= wr_en;
        // a lone prekick arms; repeating the same one keeps it armed only
        prekick1_reg <= (op == OP_PRE1) && !pair_done;
        prekick2_reg <= (op == OP_PRE2) && !pair_done;
        if (op == OP_CALL) begin
          stack_mem[sp_reg] <= pc_inc;
          sp_reg <= sp_reg + MIEU_SPW'(1);
        end
        if (is_ret)
          sp_reg <= sp_top;
        if (op == OP_RETURN_FROM_IRQ)
          irq_en_reg <= 1'b1;
        if (is_tbl) begin
          paddr_reg <= {tbl_hi, m};
          tbl_addr_reg <= instr_in.mem_addr;
          tbl_pend_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
      instr_ready_out <= 1'b0;
    end else begin
      ack_reg <= bus_req;
      rdata_reg <= rd_mux;
      instr_ready_out <= (state_next == ST_EXEC) && !(issue && is_tbl);
    end
  end

  assign avs_waitrequest = !ack_reg;
  assign avs_readdata = rdata_reg;
  assign mem_addr_out = issue ? instr_in.mem_addr : maddr_reg;
  assign mem_wdata_out = mwdata_reg;
  assign mem_we_out = mwe_reg;
  assign prog_addr_out = paddr_reg;
  assign pc_out = pc_reg;
  assign working_register_out = acc_reg;
  assign table_high_latch_out = table_high_latch_reg;
  assign flags_out = flags_reg;
  assign global_irq_enable_out = irq_en_reg;
  assign halted_out = state_reg == ST_HALT;

  property p_move_flags;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && (op == OP_MOV_A_M || op == OP_MOV_M_A || op == OP_MOV_A_X)
      |=> flags_reg == $past(flags_reg) && ((state_reg == ST_DUMMY) == $past(pc_write));
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move changed flags");

  sequence s_call;
    issue && op == OP_CALL;
  endsequence
  property p_call;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      s_call |=> state_reg == ST_DUMMY && stack_mem[sp_top] == $past(pc_inc);
  endproperty
  a_call: assert property (p_call) else $error("call push wrong");

  property p_skip;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && skip |=> state_reg == ST_DUMMY ##1 state_reg == ST_EXEC;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not two cycles");

  property p_pcl;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && pc_write |=> state_reg == ST_DUMMY && pc_reg[DW-1:0] == $past(wr_data);
  endproperty
  a_pcl: assert property (p_pcl) else $error("pc low write wrong");

  property p_reta;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && op == OP_RETA |=> acc_reg == $past(instr_in.literal) && state_reg == ST_DUMMY;
  endproperty
  a_reta: assert property (p_reta) else $error("literal return wrong");

  property p_kick;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && op == OP_KICK
      |=> watchdog_counter_reg == MIEU_WDT_RST && !flags_reg[FLG_TO] && !flags_reg[FLG_PD];
  endproperty
  a_kick: assert property (p_kick) else $error("kick failed");

  property p_lone_pre;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && op == OP_PRE1 && !prekick2_reg |=> flags_reg[5:4] == $past(flags_reg[5:4]);
  endproperty
  a_lone_pre: assert property (p_lone_pre) else $error("lone prekick acted");

  property p_halt;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && op == OP_HALT |=> halted_out && flags_reg[FLG_PD] && !flags_reg[FLG_TO];
  endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");

  property p_return_from_irq;
    @(posedge core_clk_in) disable iff (!reset_n_in)
      issue && op == OP_RETURN_FROM_IRQ |=> global_irq_enable_out;
  endproperty
  a_return_from_irq: assert property (p_return_from_irq) else $error("irq enable not set");
endmodule
`default_nettype wire

// ==== bench/mieu_core_tb.sv ====
/*
  Self-checking bench for the execute unit: scenario tasks issue
  instructions, model data and program memory, use the register bus.
  Assumes the core and its package, one 25 MHz clock, async low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %0h exp %0h", $time, (g), (e)); end end
module mieu_core_tb;
  import mieu_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  mieu_instr_t instr_in = '0;
  logic instr_valid_in = 1'b0;
  logic wake_in = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic instr_ready_out, mem_we_out, global_irq_enable_out, halted_out, avs_waitrequest;
  logic [7:0] mem_addr_out, mem_wdata_out, working_register_out, table_high_latch_out;
  logic [15:0] prog_addr_out;
  logic [12:0] pc_out;
  logic [5:0] flags_out;
  logic [31:0] avs_readdata;
  logic [7:0] mem [256];
  int bad_count = 0;
  int comparisons = 0;
  wire logic [7:0] mem_rdata = mem[mem_addr_out];
  // program word is a fixed mix of its address, so no table image is needed
  wire logic [15:0] prog_rdata = {~prog_addr_out[7:0], prog_addr_out[15:8]};

  always #20 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (mem_we_out === 1'b1) mem[mem_addr_out] <= mem_wdata_out;

  mieu_core DUT (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .instr_in(instr_in),
    .instr_valid_in(instr_valid_in),
    .instr_ready_out(instr_ready_out),
    .wake_in(wake_in),
    .mem_rdata_in(mem_rdata),
    .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out),
    .mem_we_out(mem_we_out),
    .prog_addr_out(prog_addr_out),
    .prog_rdata_in(prog_rdata),
    .pc_out(pc_out),
    .working_register_out(working_register_out),
    .table_high_latch_out(table_high_latch_out),
    .flags_out(flags_out),
    .global_irq_enable_out(global_irq_enable_out),
    .halted_out(halted_out),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic hang();
    bad_count++;
    $display("ERROR %0t wait ran out", $time);
    give_verdict();
  endtask

  function automatic mieu_instr_t mk(mieu_op_t op, logic [7:0] a = 8'h00,
      logic [7:0] x = 8'h00, logic [2:0] b = 3'h0, logic [3:0] s = 4'h0,
      logic [12:0] t = 13'h0000);
    mk = {op, s, b, a, x, t};
  endfunction

  // ends in the cycle after issue; ready there tells one cycle from two
  task automatic run(input mieu_instr_t ins, input logic fast);
    int n;
    n = 0;
    @(posedge core_clk_in);
    instr_in <= ins;
    instr_valid_in <= 1'b1;
    @(negedge core_clk_in);
    while (instr_ready_out !== 1'b1) begin
      n++;
      if (n > 200) hang();
      @(negedge core_clk_in);
    end
    @(posedge core_clk_in);
    instr_valid_in <= 1'b0;
    @(negedge core_clk_in);
    `CHK(instr_ready_out, fast)
  endtask

  task automatic settle();
    @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk_in);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // waitrequest and read data taken as they stand at the rising edge
    do begin
      @(posedge core_clk_in);
      n++;
      if (n > 200) hang();
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic t_bus();
    logic [31:0] q;
    run(mk(OP_MOV_A_X, 8'h00, 8'h3c), 1'b1);
    bus(1'b1, 4'h0, 32'h0000_0012, q);
    bus(1'b0, 4'h0, 32'h0, q);
    `CHK(q[7:0], 8'h12)
    bus(1'b1, 4'h3, 32'h0000_00aa, q);
    bus(1'b0, 4'h3, 32'h0, q);
    `CHK(q, 32'h0000_003c)
    bus(1'b0, 4'h2, 32'h0, q);
    `CHK(q, 32'h0000_0001)
    bus(1'b0, 4'h1, 32'h0, q);
    `CHK(q, 32'h0000_0000)
    bus(1'b1, 4'h9, 32'h0000_0055, q);
    bus(1'b0, 4'h9, 32'h0, q);
    `CHK(q, 32'h0)
  endtask

  task automatic t_move();
    logic [5:0] f;
    f = flags_out;
    mem[8'h10] = 8'h5a;
    run(mk(OP_MOV_A_X, 8'h00, 8'h3c), 1'b1);
    `CHK(working_register_out, 8'h3c)
    run(mk(OP_MOV_A_M, 8'h10), 1'b1);
    `CHK(working_register_out, 8'h5a)
    run(mk(OP_MOV_M_A, 8'h20), 1'b1);
    settle();
    `CHK(mem[8'h20], 8'h5a)
    `CHK(flags_out, f)
  endtask

  // s is {with_carry, literal, to_mem, logic_and}
  task automatic t_alu(input logic [3:0] s, input logic [7:0] w, input logic [7:0] m,
      input logic [7:0] x);
    logic [5:0] f;
    logic [8:0] sum;
    logic [7:0] b, r;
    logic ci;
    run(mk(OP_MOV_A_X, 8'h00, w), 1'b1);
    mem[8'h05] = m;
    f = flags_out;
    b = s[2] ? x : m;
    ci = s[3] & f[FLG_C];
    sum = {1'b0, w} + {1'b0, b} + {8'h00, ci};
    r = s[0] ? (w & b) : sum[7:0];
    f[FLG_Z] = (r == 8'h00);
    if (!s[0]) begin
      f[FLG_C] = sum[8];
      f[FLG_AC] = ({1'b0, w[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0f;
      f[FLG_OV] = (w[7] == b[7]) && (r[7] != w[7]);
    end
    run(mk(OP_ADD, 8'h05, x, 3'h0, s), 1'b1);
    settle();
    `CHK(flags_out, f)
    `CHK(s[1] ? mem[8'h05] : working_register_out, r)
    `CHK(s[1] ? working_register_out : mem[8'h05], s[1] ? w : m)
  endtask

  task automatic t_bits();
    logic [5:0] f;
    f = flags_out;
    mem[8'h30] = 8'ha5;
    run(mk(OP_BCLR, 8'h30, 8'h00, 3'h0), 1'b1);
    run(mk(OP_BSET, 8'h30, 8'h00, 3'h6), 1'b1);
    settle();
    `CHK(mem[8'h30], 8'he4)
    run(mk(OP_SWAP, 8'h30), 1'b1);
    run(mk(OP_NIBBLE_SWAP_TO_REGISTER, 8'h30), 1'b1);
    settle();
    `CHK(mem[8'h30], 8'h4e)
    `CHK(working_register_out, 8'he4)
    run(mk(OP_CLR, 8'h30), 1'b1);
    settle();
    `CHK(mem[8'h30], 8'h00)
    run(mk(OP_SET, 8'h30), 1'b1);
    settle();
    `CHK(mem[8'h30], 8'hff)
    `CHK(flags_out, f)
  endtask

  task automatic sk(input mieu_op_t op, input logic [7:0] m, input logic [2:0] b,
      input logic fast, input logic [7:0] em, input logic [7:0] ew);
    logic [5:0] f;
    mem[8'h40] = m;
    run(mk(OP_MOV_A_X, 8'h00, 8'h77), 1'b1);
    f = flags_out;
    run(mk(op, 8'h40, 8'h00, b), fast);
    settle();
    `CHK(mem[8'h40], em)
    `CHK(working_register_out, ew)
    `CHK(flags_out, f)
  endtask

  task automatic t_tab(input mieu_op_t op, input logic [7:0] pg, input logic full);
    logic [5:0] f;
    f = flags_out;
    mem[8'h50] = 8'h34;
    run(mk(op, 8'h50), 1'b0);
    `CHK(prog_addr_out[7:0], 8'h34)
    if (full) `CHK(prog_addr_out[15:8], pg)
    repeat (4) @(posedge core_clk_in);
    @(negedge core_clk_in);
    `CHK(table_high_latch_out, 8'hcb)
    if (full) `CHK(mem[8'h50], pg)
    `CHK(flags_out, f)
  endtask

  task automatic t_flow();
    run(mk(OP_JMP, 8'h00, 8'h00, 3'h0, 4'h0, 13'h0123), 1'b0);
    `CHK(pc_out, 13'h0123)
    run(mk(OP_CALL, 8'h00, 8'h00, 3'h0, 4'h0, 13'h0456), 1'b0);
    `CHK(pc_out, 13'h0456)
    run(mk(OP_RET), 1'b0);
    `CHK(pc_out, 13'h0124)
    run(mk(OP_CALL, 8'h00, 8'h00, 3'h0, 4'h0, 13'h0200), 1'b0);
    run(mk(OP_RETA, 8'h00, 8'h99), 1'b0);
    `CHK(pc_out, 13'h0125)
    `CHK(working_register_out, 8'h99)
    run(mk(OP_CALL, 8'h00, 8'h00, 3'h0, 4'h0, 13'h0300), 1'b0);
    run(mk(OP_RETURN_FROM_IRQ), 1'b0);
    `CHK(pc_out, 13'h0126)
    `CHK(global_irq_enable_out, 1'b1)
    run(mk(OP_MOV_M_A, MIEU_PCL_ADDR), 1'b0);
    run(mk(OP_NOP), 1'b1);
  endtask

  task automatic halt_wake();
    logic [5:0] f;
    f = flags_out;
    run(mk(OP_HALT), 1'b0);
    `CHK(halted_out, 1'b1)
    `CHK({flags_out[FLG_TO], flags_out[FLG_PD]}, 2'b01)
    `CHK(flags_out[3:0], f[3:0])
    repeat (3) @(negedge core_clk_in);
    `CHK(instr_ready_out, 1'b0)
    @(posedge core_clk_in);
    wake_in <= 1'b1;
    @(posedge core_clk_in);
    wake_in <= 1'b0;
  endtask

  task automatic kick(input mieu_op_t op, input logic pd);
    run(mk(op), 1'b1);
    `CHK(flags_out[FLG_PD], pd)
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (16) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    t_bus();
    t_move();
    t_alu(4'b0100, 8'h8f, 8'h00, 8'h71);
    t_alu(4'b1010, 8'h80, 8'h7f, 8'h00);
    t_alu(4'b1000, 8'h10, 8'h2f, 8'h00);
    t_alu(4'b0010, 8'h80, 8'h80, 8'h00);
    t_alu(4'b0000, 8'h44, 8'h3c, 8'h00);
    t_alu(4'b0001, 8'hf0, 8'h0f, 8'h00);
    t_alu(4'b0101, 8'hf3, 8'h00, 8'h3e);
    t_alu(4'b0011, 8'h3c, 8'h0f, 8'h00);
    t_bits();
    sk(OP_SZ, 8'h00, 3'h0, 1'b0, 8'h00, 8'h77);
    sk(OP_SZ, 8'h01, 3'h0, 1'b1, 8'h01, 8'h77);
    sk(OP_SZB, 8'hfe, 3'h0, 1'b0, 8'hfe, 8'h77);
    sk(OP_SZB, 8'hfe, 3'h1, 1'b1, 8'hfe, 8'h77);
    sk(OP_SNZB, 8'h80, 3'h7, 1'b0, 8'h80, 8'h77);
    sk(OP_SNZB, 8'h80, 3'h6, 1'b1, 8'h80, 8'h77);
    sk(OP_SIZ, 8'hff, 3'h0, 1'b0, 8'h00, 8'h77);
    sk(OP_SDZ, 8'h02, 3'h0, 1'b1, 8'h01, 8'h77);
    sk(OP_INC_TO_REG_SKIP_IF_NULL, 8'hff, 3'h0, 1'b0, 8'hff, 8'h00);
    sk(OP_DEC_TO_REG_SKIP_IF_NULL, 8'h05, 3'h0, 1'b1, 8'h05, 8'h04);
    sk(OP_SZA, 8'h00, 3'h0, 1'b0, 8'h00, 8'h00);
    sk(OP_SZA, 8'h07, 3'h0, 1'b1, 8'h07, 8'h07);
    t_tab(OP_TABLE_READ_SPECIFIC_PAGE_S, 8'h12, 1'b1);
    t_tab(OP_TABLE_READ_SPECIFIC_PAGE_L, MIEU_LAST_PAGE, 1'b1);
    t_tab(OP_TABLE_READ_SPECIFIC_PAGE_C, 8'h00, 1'b0);
    t_flow();
    halt_wake();
    kick(OP_KICK, 1'b0);
    halt_wake();
    kick(OP_PRE1, 1'b1);
    kick(OP_PRE1, 1'b1);
    kick(OP_PRE2, 1'b0);
    halt_wake();
    kick(OP_PRE2, 1'b1);
    run(mk(OP_NOP), 1'b1);
    kick(OP_PRE1, 1'b1);
    kick(OP_PRE2, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
